// file: shared/psq_pkg.sv
package psq_pkg;

  // System clock rate and low-power clock rate.
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned SLOW_CLK_HZ = 32768;
  // System clock cycles per low-power clock period, rounded down.
  localparam int unsigned SLOW_PERIOD_CYC = CLK_HZ / SLOW_CLK_HZ;

  // Default sizes of the resource table.
  localparam int unsigned NRES_DEF = 8;
  localparam int unsigned TW_DEF   = 8;
  localparam int unsigned NCLK_DEF = 4;

  // Resource indices that steer the regulator enables.
  localparam int unsigned RES_CORE_LIN  = 1;
  localparam int unsigned RES_LOW_NOISE = 2;

  // Bit positions of the synchronised pin vector.
  localparam int unsigned PIN_WLAN = 0;
  localparam int unsigned PIN_BT   = 1;
  localparam int unsigned PIN_SLOW = 2;
  localparam int unsigned PIN_IRQ  = 3;
  localparam int unsigned PIN_SDIO = 4;
  localparam int unsigned NPIN     = 5;

  // Chip power states, one-hot.
  typedef enum logic [5:0] {
    PS_OFF     = 6'h01,
    PS_ACTIVE  = 6'h02,
    PS_DOZE    = 6'h04,
    PS_SAVE    = 6'h08,
    PS_DEEP    = 6'h10,
    PS_RESTORE = 6'h20
  } psq_pstate_t;

  // Regulator enables.
  typedef struct packed {
    logic buck;
    logic core_lin;
    logic low_noise;
  } psq_reg_en_t;

  // I/O safe-state controls, high means disabled.
  typedef struct packed {
    logic out_dis;
    logic in_dis;
  } psq_io_t;

endpackage

// file: hdl/psq_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; the output follows once stages two and three agree.
module psq_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } psq_sync_st_t;

  psq_sync_st_t st_ff;
  psq_sync_st_t nxt_st;

  // Stage one feeds only stage two; the agreement test looks at two and three.
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dout = st_ff.q;

endmodule
`default_nettype wire

// file: hdl/psq_resource_slot.sv
`timescale 1ns/1ps
`default_nettype none
// One resource: on-state bit, pending bit and its countdown timer.
module psq_resource_slot #(
  parameter int unsigned TW = psq_pkg::TW_DEF
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          tick,
  input  wire logic          clear,
  input  wire logic          requested,
  input  wire logic          deps_ok,
  input  wire logic          no_dependents,
  input  wire logic [TW-1:0] time_on,
  input  wire logic [TW-1:0] time_off,
  output logic               on_state,
  output logic               pending
);

  typedef struct packed {
    logic          on;
    logic          pend;
    logic [TW-1:0] timer;
  } psq_slot_st_t;

  psq_slot_st_t st_ff;
  psq_slot_st_t nxt_st;

  // Stable states hold a zero timer; transitions hold a nonzero one.
  always_comb begin
    nxt_st = st_ff;
    if (clear) begin
      nxt_st = '0;
    end else if (tick) begin
      if (st_ff.timer != '0) begin
        nxt_st.timer = st_ff.timer - TW'(1);
        if (st_ff.timer == TW'(1)) begin
          nxt_st.pend = 1'b0;
          nxt_st.on   = ~st_ff.on;
        end
      end else if (st_ff.on && !requested && no_dependents) begin
        // A zero delay skips the transition state entirely.
        if (time_off == '0) begin
          nxt_st.on = 1'b0;
        end else begin
          nxt_st.timer = time_off;
          nxt_st.pend  = 1'b1;
        end
      end else if (!st_ff.on && requested && deps_ok) begin
        if (time_on == '0) begin
          nxt_st.on = 1'b1;
        end else begin
          nxt_st.timer = time_on;
          nxt_st.pend  = 1'b1;
        end
      end
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign on_state = st_ff.on;
  assign pending  = st_ff.pend;

endmodule
`default_nettype wire

// file: hdl/psq_power_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module psq_power_sequencer #(
  parameter int unsigned NRES = psq_pkg::NRES_DEF,
  parameter int unsigned TW   = psq_pkg::TW_DEF,
  parameter int unsigned NCLK = psq_pkg::NCLK_DEF
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       wlan_power_on_request,
  input  wire logic                       bt_power_on_request,
  input  wire logic                       low_power_clock,
  input  wire logic                       wake_ext_irq,
  input  wire logic                       wake_sdio_resume,
  input  wire logic [NCLK-1:0]            core_clock_request,
  input  wire logic [NCLK-1:0][NRES-1:0]  clock_resource_map,
  input  wire logic [NRES-1:0]            minimum_resource_mask,
  input  wire logic [NRES-1:0][NRES-1:0]  resource_dependency,
  input  wire logic [NRES-1:0][TW-1:0]    resource_time_on,
  input  wire logic [NRES-1:0][TW-1:0]    resource_time_off,
  input  wire logic                       req_timer_load,
  input  wire logic [TW-1:0]              req_timer_ticks,
  input  wire logic [NRES-1:0]            req_timer_mask,
  input  wire logic                       doze_request,
  input  wire logic                       deep_sleep_request,
  input  wire logic                       retention_save_done,
  input  wire logic                       retention_restore_done,
  output psq_pkg::psq_reg_en_t            reg_en,
  output logic                            wlan_reset_n,
  output logic                            bt_reset_n,
  output logic                            main_clock_en,
  output logic                            retention_save_req,
  output logic                            retention_restore_req,
  output psq_pkg::psq_io_t                io_safe,
  output psq_pkg::psq_pstate_t            power_state,
  output logic [NRES-1:0]                 resource_on_state,
  output logic [NRES-1:0]                 resource_transition_pending
);

  typedef struct packed {
    psq_pkg::psq_pstate_t ps;
    logic                 slow_q;
    logic [TW-1:0]        rtimer;
    logic [NRES-1:0]      rmask;
    logic                 timer_wake;
    logic                 save_req;
    logic                 restore_req;
    psq_pkg::psq_reg_en_t reg_en;
    psq_pkg::psq_io_t     io;
    logic                 wlan_rst_n;
    logic                 bt_rst_n;
    logic                 mclk_en;
  } psq_top_st_t;

  psq_top_st_t st_ff;
  psq_top_st_t nxt_st;

  logic [psq_pkg::NPIN-1:0] pins_raw;
  logic [psq_pkg::NPIN-1:0] pins;
  logic                     wlan_on;
  logic                     bt_on;
  logic                     any_on;
  logic                     slow_tick;
  logic                     wake_evt;
  logic [NRES-1:0]          request;
  logic [NRES-1:0]          required;
  logic [NRES-1:0]          enabled;
  logic [NRES-1:0]          deps_ok;
  logic [NRES-1:0]          no_dep;
  logic [NRES-1:0]          on_st;
  logic [NRES-1:0]          pend_st;

  // All pins come from outside this clock and share one synchroniser.
  assign pins_raw[psq_pkg::PIN_WLAN] = wlan_power_on_request;
  assign pins_raw[psq_pkg::PIN_BT]   = bt_power_on_request;
  assign pins_raw[psq_pkg::PIN_SLOW] = low_power_clock;
  assign pins_raw[psq_pkg::PIN_IRQ]  = wake_ext_irq;
  assign pins_raw[psq_pkg::PIN_SDIO] = wake_sdio_resume;

  psq_sync #(
    .WIDTH (psq_pkg::NPIN)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (pins_raw),
    .dout  (pins)
  );

  // Power-on inputs are OR-ed for regulator power.
  assign wlan_on = pins[psq_pkg::PIN_WLAN];
  assign bt_on   = pins[psq_pkg::PIN_BT];
  assign any_on  = wlan_on | bt_on;

  // The low-power clock becomes a one-cycle enable on its rising edge.
  assign slow_tick = pins[psq_pkg::PIN_SLOW] & ~st_ff.slow_q;

  // Wake sources for doze and deep sleep.
  assign wake_evt = st_ff.timer_wake | pins[psq_pkg::PIN_IRQ] | pins[psq_pkg::PIN_SDIO];

  // Request union, then closure over the dependency table.
  // The closure uses NRES passes so chains of any length are covered in one tick.
  always_comb begin
    request = minimum_resource_mask;
    if (st_ff.rtimer != '0) begin
      request = request | st_ff.rmask;
    end
    for (int c = 0; c < NCLK; c++) begin
      if (core_clock_request[c]) begin
        request = request | clock_resource_map[c];
      end
    end
    required = request;
    for (int p = 0; p < NRES; p++) begin
      for (int r = 0; r < NRES; r++) begin
        if (required[r]) begin
          required = required | resource_dependency[r];
        end
      end
    end
  end

  // Dependency checks against the current resource status.
  always_comb begin
    enabled = on_st & ~pend_st;
    for (int r = 0; r < NRES; r++) begin
      deps_ok[r] = ((resource_dependency[r] & ~enabled) == '0);
      no_dep[r]  = 1'b1;
      for (int d = 0; d < NRES; d++) begin
        if (on_st[d] && resource_dependency[d][r]) begin
          no_dep[r] = 1'b0;
        end
      end
    end
  end

  // One slot per resource, all advanced by the same low-power tick.
  for (genvar g = 0; g < NRES; g++) begin : g_slot
    psq_resource_slot #(
      .TW (TW)
    ) u_slot (
      .clk           (clk),
      .rst_n         (rst_n),
      .tick          (slow_tick),
      .clear         (~any_on),
      .requested     (required[g]),
      .deps_ok       (deps_ok[g]),
      .no_dependents (no_dep[g]),
      .time_on       (resource_time_on[g]),
      .time_off      (resource_time_off[g]),
      .on_state      (on_st[g]),
      .pending       (pend_st[g])
    );
  end

  // Chip power state, request timer and registered outputs.
  always_comb begin
    nxt_st            = st_ff;
    nxt_st.slow_q     = pins[psq_pkg::PIN_SLOW];
    nxt_st.timer_wake = 1'b0;
    // Request timer runs on low-power ticks; its expiry is a wake event.
    if (req_timer_load) begin
      nxt_st.rtimer = req_timer_ticks;
      nxt_st.rmask  = req_timer_mask;
    end else if (slow_tick && st_ff.rtimer != '0) begin
      nxt_st.rtimer = st_ff.rtimer - TW'(1);
      if (st_ff.rtimer == TW'(1)) begin
        nxt_st.timer_wake = 1'b1;
      end
    end
    case (st_ff.ps)
      psq_pkg::PS_OFF: begin
        if (any_on) begin
          nxt_st.ps = psq_pkg::PS_ACTIVE;
        end
      end
      psq_pkg::PS_ACTIVE: begin
        if (deep_sleep_request) begin
          nxt_st.ps = psq_pkg::PS_SAVE;
        end else if (doze_request) begin
          nxt_st.ps = psq_pkg::PS_DOZE;
        end
      end
      psq_pkg::PS_DOZE: begin
        if (wake_evt || !doze_request) begin
          nxt_st.ps = psq_pkg::PS_ACTIVE;
        end
      end
      psq_pkg::PS_SAVE: begin
        // Core power stays up until the retention copy is confirmed.
        if (retention_save_done) begin
          nxt_st.ps = psq_pkg::PS_DEEP;
        end
      end
      psq_pkg::PS_DEEP: begin
        if (wake_evt) begin
          nxt_st.ps = psq_pkg::PS_RESTORE;
        end
      end
      psq_pkg::PS_RESTORE: begin
        if (retention_restore_done) begin
          nxt_st.ps = psq_pkg::PS_ACTIVE;
        end
      end
      default: begin
        nxt_st.ps = psq_pkg::PS_OFF;
      end
    endcase
    // Both inputs low overrides everything and returns all state to reset, except slow_q, which keeps following the low-power clock pin.
    if (!any_on) begin
      nxt_st = '0;
      nxt_st.ps    = psq_pkg::PS_OFF;
      nxt_st.slow_q = pins[psq_pkg::PIN_SLOW];
    end
    nxt_st.save_req    = (nxt_st.ps == psq_pkg::PS_SAVE);
    nxt_st.restore_req = (nxt_st.ps == psq_pkg::PS_RESTORE);
    // Deep sleep drops buck and both linear regulators together.
    nxt_st.reg_en.buck  = any_on && (nxt_st.ps != psq_pkg::PS_DEEP);
    nxt_st.reg_en.core_lin  = nxt_st.reg_en.buck && on_st[psq_pkg::RES_CORE_LIN];
    nxt_st.reg_en.low_noise = nxt_st.reg_en.buck && on_st[psq_pkg::RES_LOW_NOISE];
    nxt_st.io.out_dis   = (nxt_st.ps == psq_pkg::PS_OFF);
    nxt_st.io.in_dis    = (nxt_st.ps == psq_pkg::PS_OFF);
    nxt_st.wlan_rst_n   = wlan_on;
    nxt_st.bt_rst_n     = bt_on;
    // Main clocks run only in active and the save and restore steps.
    nxt_st.mclk_en = (nxt_st.ps == psq_pkg::PS_ACTIVE) || (nxt_st.ps == psq_pkg::PS_SAVE) ||
                     (nxt_st.ps == psq_pkg::PS_RESTORE);
  end

  // State register; reset leaves the chip powered down with I/O safe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff        <= '0;
      st_ff.ps     <= psq_pkg::PS_OFF;
      st_ff.io     <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_en                      = st_ff.reg_en;
  assign wlan_reset_n                = st_ff.wlan_rst_n;
  assign bt_reset_n                  = st_ff.bt_rst_n;
  assign main_clock_en               = st_ff.mclk_en;
  assign retention_save_req          = st_ff.save_req;
  assign retention_restore_req       = st_ff.restore_req;
  assign io_safe                     = st_ff.io;
  assign power_state                 = st_ff.ps;
  assign resource_on_state           = on_st;
  assign resource_transition_pending = pend_st;

endmodule
`default_nettype wire

// file: sim/psq_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the power-on pins, plus the free-running low-power oscillator.
module psq_host_model #(
  parameter int unsigned HALF = 8
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic w_cmd,
  input  wire logic b_cmd,
  output logic      wlan_pin,
  output logic      bt_pin,
  output logic      slow_clk
);
  int unsigned cnt;
  // Pins move just after an edge; only the host can lift the chip out of power-down.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wlan_pin <= 1'h0;
      bt_pin   <= 1'h0;
      slow_clk <= 1'h0;
      cnt      <= 0;
    end else begin
      wlan_pin <= w_cmd;
      bt_pin   <= b_cmd;
      cnt      <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        slow_clk <= ~slow_clk;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/psq_power_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Checks the sequencer outputs against the power-on pins and its own state.
module psq_power_sequencer_chk #(
  parameter int unsigned NRES = 8
) (
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire logic                 wlan_power_on_request,
  input wire logic                 bt_power_on_request,
  input wire psq_pkg::psq_reg_en_t reg_en,
  input wire logic                 main_clock_en,
  input wire psq_pkg::psq_io_t     io_safe,
  input wire psq_pkg::psq_pstate_t power_state,
  input wire logic [NRES-1:0]      resource_on_state,
  input wire logic [NRES-1:0]      resource_transition_pending
);
  logic any_on;
  // Pins pass a synchroniser, so eight steady cycles leave margin for its latency.
  assign any_on = wlan_power_on_request | bt_power_on_request;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_all_off: assert property ((!any_on)[*8] |->
    power_state == psq_pkg::PS_OFF && reg_en == 3'h0 && resource_on_state == '0)
    else $error("state kept with both power-on pins low");
  a_any_buck: assert property (any_on[*8] |-> reg_en.buck ||
    power_state == psq_pkg::PS_DEEP || $past(power_state) == psq_pkg::PS_DEEP)
    else $error("buck regulator off with a power-on pin high");
  a_io_off: assert property (power_state == psq_pkg::PS_OFF |-> io_safe == 2'h3)
    else $error("pins not in safe state while off");
  a_deep_off: assert property (power_state == psq_pkg::PS_DEEP &&
    $past(power_state) == psq_pkg::PS_DEEP |-> reg_en == 3'h0)
    else $error("regulator on in deep sleep");
  a_doze_clk: assert property (power_state == psq_pkg::PS_DOZE &&
    $past(power_state) == psq_pkg::PS_DOZE |-> !main_clock_en)
    else $error("main clock running in doze");
  a_save_first: assert property ($rose(power_state == psq_pkg::PS_DEEP) |->
    $past(power_state) == psq_pkg::PS_SAVE)
    else $error("deep sleep entered without saving state");
  a_deep_exit: assert property ($past(power_state) == psq_pkg::PS_DEEP |->
    power_state inside {psq_pkg::PS_DEEP, psq_pkg::PS_RESTORE, psq_pkg::PS_OFF})
    else $error("deep sleep left without restore");
  a_pend_flip: assert property (power_state == psq_pkg::PS_OFF ||
    ($past(resource_transition_pending) & ~resource_transition_pending &
     ~($past(resource_on_state) ^ resource_on_state)) == '0)
    else $error("pending cleared without on-state change");
  c_deep: cover property (power_state == psq_pkg::PS_DEEP);
  c_doze: cover property (power_state == psq_pkg::PS_DOZE);
  c_pend: cover property (|resource_transition_pending);
endmodule
bind psq_power_sequencer psq_power_sequencer_chk #(.NRES(NRES)) psq_power_sequencer_chk_i (
  .clk, .rst_n, .wlan_power_on_request, .bt_power_on_request, .reg_en, .main_clock_en,
  .io_safe, .power_state, .resource_on_state, .resource_transition_pending);
`default_nettype wire

// file: sim/tb_psq_power_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_psq_power_sequencer;
  logic                 clk, rst_n, wc, bc, wl, bt, slw, irq, sdio, doze, deep, sd, rd, tl;
  logic                 wrst, brst, mclk, sreq, rreq;
  logic [3:0]           creq;
  logic [3:0][7:0]      cmap;
  logic [7:0]           minm, tm, tt, on_s, pend;
  logic [7:0][7:0]      dep, ton, toff;
  psq_pkg::psq_reg_en_t reg_en;
  psq_pkg::psq_io_t     io;
  psq_pkg::psq_pstate_t ps;
  int                   n_errors = 0, n_checks = 0, cyc = 0;
  psq_host_model psq_host_model_i (.clk(clk), .rst_n(rst_n), .w_cmd(wc), .b_cmd(bc),
    .wlan_pin(wl), .bt_pin(bt), .slow_clk(slw));
  psq_power_sequencer psq_power_sequencer_i (.clk(clk), .rst_n(rst_n),
    .wlan_power_on_request(wl), .bt_power_on_request(bt), .low_power_clock(slw),
    .wake_ext_irq(irq), .wake_sdio_resume(sdio), .core_clock_request(creq),
    .clock_resource_map(cmap), .minimum_resource_mask(minm), .resource_dependency(dep),
    .resource_time_on(ton), .resource_time_off(toff), .req_timer_load(tl),
    .req_timer_ticks(tt), .req_timer_mask(tm), .doze_request(doze),
    .deep_sleep_request(deep), .retention_save_done(sd), .retention_restore_done(rd),
    .reg_en(reg_en), .wlan_reset_n(wrst), .bt_reset_n(brst), .main_clock_en(mclk),
    .retention_save_req(sreq), .retention_restore_req(rreq), .io_safe(io),
    .power_state(ps), .resource_on_state(on_s), .resource_transition_pending(pend));
  task automatic stop_test;
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmp_vec(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Pins need the synchroniser plus an output stage; ten cycles cover both.
  task automatic set_pins(input logic w, input logic b);
    @(posedge clk);
    wc <= w;
    bc <= b;
    repeat (10) @(negedge clk);
  endtask
  task automatic wait_st(input psq_pkg::psq_pstate_t s);
    for (int i = 0; i < 3000 && ps !== s; i++) @(negedge clk);
    @(negedge clk);
    cmp_vec("power_state", 8'(s), 8'(ps));
  endtask
  // Counts oscillator rises after pending shows, which equals the loaded delay.
  task automatic wait_on(input int k, input logic v, output int tk, output logic sp);
    logic lp;
    tk = 0;
    sp = 1'h0;
    lp = slw;
    for (int i = 0; i < 3000 && on_s[k] !== v; i++) begin
      @(negedge clk);
      if (sp && slw && !lp) tk++;
      sp = sp | (pend[k] === 1'h1);
      lp = slw;
    end
    cmp_bit("resource_on_state", v, on_s[k]);
  endtask
  task automatic t_pins;
    set_pins(1'h1, 1'h0);
    wait_st(psq_pkg::PS_ACTIVE);
    cmp_bit("buck", 1'h1, reg_en.buck);
    cmp_bit("wlan_reset_n", 1'h1, wrst);
    cmp_bit("bt_reset_n", 1'h0, brst);
    cmp_vec("io_safe", 8'h00, 8'(io));
    set_pins(1'h0, 1'h1);
    cmp_bit("buck", 1'h1, reg_en.buck);
    cmp_bit("bt_reset_n", 1'h1, brst);
    cmp_bit("wlan_reset_n", 1'h0, wrst);
    set_pins(1'h0, 1'h0);
    cmp_vec("power_state", 8'(psq_pkg::PS_OFF), 8'(ps));
    cmp_vec("reg_en", 8'h00, 8'(reg_en));
    cmp_vec("io_safe", 8'h03, 8'(io));
  endtask
  // Resource 2 depends on 1; resource 3 has no delay and rides the request timer.
  task automatic t_res;
    logic sp;
    int   tk;
    @(posedge clk);
    ton  <= {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00};
    toff <= {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h02, 8'h00};
    dep[2] <= 8'h02;
    cmap[0] <= 8'h04;
    set_pins(1'h1, 1'h0);
    wait_st(psq_pkg::PS_ACTIVE);
    @(posedge clk);
    minm <= 8'h02;
    creq <= 4'h1;
    wait_on(1, 1'h1, tk, sp);
    cmp_vec("ticks", 8'h03, 8'(tk));
    cmp_bit("pending_seen", 1'h1, sp);
    cmp_bit("dependent_on", 1'h0, on_s[2]);
    repeat (2) @(negedge clk);
    cmp_bit("core_lin_en", 1'h1, reg_en.core_lin);
    wait_on(2, 1'h1, tk, sp);
    cmp_vec("ticks", 8'h01, 8'(tk));
    repeat (2) @(negedge clk);
    cmp_bit("low_noise_en", 1'h1, reg_en.low_noise);
    @(posedge clk);
    tm <= 8'h08;
    tt <= 8'h06;
    tl <= 1'h1;
    @(posedge clk);
    tl <= 1'h0;
    wait_on(3, 1'h1, tk, sp);
    cmp_bit("pending_seen", 1'h0, sp);
    wait_on(3, 1'h0, tk, sp);
    @(posedge clk);
    minm <= 8'h00;
    creq <= 4'h0;
    wait_on(2, 1'h0, tk, sp);
    cmp_vec("ticks", 8'h04, 8'(tk));
    cmp_bit("provider_on", 1'h1, on_s[1]);
    wait_on(1, 1'h0, tk, sp);
    cmp_vec("ticks", 8'h02, 8'(tk));
    repeat (2) @(negedge clk);
    cmp_vec("pending", 8'h00, pend);
    cmp_bit("core_lin_en", 1'h0, reg_en.core_lin);
  endtask
  // One pass per wake source: interrupt, host resume, request timer.
  task automatic t_deep;
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      deep <= 1'h1;
      wait_st(psq_pkg::PS_SAVE);
      cmp_bit("save_req", 1'h1, sreq);
      @(posedge clk);
      deep <= 1'h0;
      sd <= 1'h1;
      @(posedge clk);
      sd <= 1'h0;
      wait_st(psq_pkg::PS_DEEP);
      cmp_vec("reg_en", 8'h00, 8'(reg_en));
      @(posedge clk);
      irq <= (s == 0);
      sdio <= (s == 1);
      tt <= 8'h03;
      tm <= 8'h00;
      tl <= (s == 2);
      @(posedge clk);
      tl <= 1'h0;
      wait_st(psq_pkg::PS_RESTORE);
      cmp_bit("restore_req", 1'h1, rreq);
      @(posedge clk);
      irq <= 1'h0;
      sdio <= 1'h0;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      wait_st(psq_pkg::PS_ACTIVE);
    end
  endtask
  task automatic t_doze;
    @(posedge clk);
    doze <= 1'h1;
    wait_st(psq_pkg::PS_DOZE);
    cmp_bit("main_clock_en", 1'h0, mclk);
    @(posedge clk);
    doze <= 1'h0;
    wait_st(psq_pkg::PS_ACTIVE);
    cmp_bit("main_clock_en", 1'h1, mclk);
  endtask
  task automatic t_restart;
    logic sp;
    int   tk;
    @(posedge clk);
    minm <= 8'h01;
    wait_on(0, 1'h1, tk, sp);
    set_pins(1'h0, 1'h0);
    cmp_vec("resource_on_state", 8'h00, on_s);
    @(posedge clk);
    minm <= 8'h00;
    set_pins(1'h0, 1'h1);
    wait_st(psq_pkg::PS_ACTIVE);
    cmp_vec("resource_on_state", 8'h00, on_s);
    cmp_bit("wlan_reset_n", 1'h0, wrst);
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      stop_test;
    end
  end
  initial begin
    rst_n = 1'h0;
    {wc, bc, irq, sdio, doze, deep, sd, rd, tl} = '0;
    {creq, cmap, minm, tm, tt, dep, ton, toff} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    t_pins;
    t_res;
    t_deep;
    t_doze;
    t_restart;
    stop_test;
  end
endmodule
`default_nettype wire
